// ==== hdl/uart_pin_pkg.sv ====
package uart_pin_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int DATA_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_INT_ENABLE = 3'h1;
    localparam logic [2:0] REG_FIFO_CTRL = 3'h2; // write: fifo control
    localparam logic [2:0] REG_INT_STATUS = 3'h2; // read: interrupt status
    localparam logic [2:0] REG_FLOW_CTRL = 3'h3;
    localparam logic [2:0] REG_MODEM_CTRL = 3'h4;
    localparam logic [2:0] REG_LINE_STATUS = 3'h5;
    localparam logic [2:0] REG_MODEM_STATUS = 3'h6;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int IER_MODEM_BIT = 3;
    localparam int FCR_ENABLE_BIT = 0;
    localparam int FCR_RX_CLEAR_BIT = 1;
    localparam int FCR_TX_CLEAR_BIT = 2;
    localparam int FCR_DMA_MODE_BIT = 3;
    localparam int FCR_TRIG_LSB = 6;
    localparam int FLOW_AUTO_RTS_BIT = 6;
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_LOOP_BIT = 4;
    localparam int LSR_RX_READY_BIT = 0;
    localparam int LSR_TX_EMPTY_BIT = 5;
    localparam int LSR_TX_IDLE_BIT = 6;
    localparam int MSR_RING_CHANGE_BIT = 2;
    localparam int MSR_RING_BIT = 6;

    // ----------------------------------------------------------------
    // receive trigger levels and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] TRIG_LEVEL_0 = 8'h01;
    localparam logic [7:0] TRIG_LEVEL_1 = 8'h04;
    localparam logic [7:0] TRIG_LEVEL_2 = 8'h08;
    localparam logic [7:0] TRIG_LEVEL_3 = 8'h0e;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic read;
        logic [2:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic modem_irq_enable;
        logic fifo_enable_bit;
        logic dma_mode_select_bit;
        logic [1:0] trigger;
        logic auto_rts;
        logic rts;
        logic loopback;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '0;

    typedef enum logic [1:0] {
        DMA_IDLE = 2'b01,
        DMA_ACTIVE = 2'b10
    } dma_state_t;

endpackage

// ==== hdl/stream_fifo.sv ====
`timescale 1ns/1ns
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    // depth must be a power of two for pointer wrap
    if (DEPTH < 2 || (2 ** AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("stream_fifo: unsupported width or depth");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] next_count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // occupancy after this cycle
    assign next_count = (push && !pop) ? count + 1'b1 :
                        (!push && pop) ? count - 1'b1 : count;
    assign out_data = mem[rd_ptr];

    // storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and honest full / empty flags
    always_ff @(posedge clk) begin
        if (clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            count <= next_count;
            in_ready <= next_count != CW'(DEPTH);
            out_valid <= next_count != '0;
        end
    end
endmodule

// ==== hdl/ring_watch.sv ====
`timescale 1ns/1ns
module ring_watch (
    input wire logic clk,
    input wire logic clear,
    input wire logic ring_n,
    input wire logic flag_read,
    output logic ring_active,
    output logic ring_change_flag,
    output logic ring_rise
);
    logic ring_prev;

    // pin rising from low to high ends a ring cycle
    assign ring_rise = !ring_prev && ring_n;

    // level capture and sticky change flag, set wins over read-clear
    always_ff @(posedge clk) begin
        if (clear) begin
            ring_prev <= 1'b1;
            ring_active <= 1'b0;
            ring_change_flag <= 1'b0;
        end else begin
            ring_prev <= ring_n;
            ring_active <= !ring_n;
            ring_change_flag <= ring_rise || (ring_change_flag && !flag_read);
        end
    end
endmodule

// ==== hdl/uart_pin_control.sv ====
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ns
module uart_pin_control #(
    parameter int DATA_WIDTH = uart_pin_pkg::DATA_WIDTH,
    parameter int FIFO_DEPTH = uart_pin_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic master_reset,
    input wire logic chip_select,
    input wire logic read_strobe,
    input wire logic read_strobe_n,
    input wire logic bus_write,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic ring_n,
    output logic rts_n,
    input wire logic tx_serial,
    output logic tx_line,
    output logic irq,
    output logic rx_dma_ready_n,
    output logic tx_dma_ready_n,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [DATA_WIDTH-1:0] rx_data,
    input wire logic rx_timeout,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [DATA_WIDTH-1:0] tx_data
);
    localparam int CW = $clog2(FIFO_DEPTH+1);

    // trigger level 14 needs at least sixteen places
    if (FIFO_DEPTH < 16 || DATA_WIDTH < 1 || DATA_WIDTH > 8)
    begin : g_bad
        $error("uart_pin_control: unsupported fifo depth or width");
    end

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    uart_pin_pkg::bus_req_t req;
    uart_pin_pkg::ctrl_t ctrl;
    uart_pin_pkg::ctrl_t next_ctrl;
    logic rst;
    logic read_any;
    // master reset acts like the system reset on all control state
    assign rst = !reset_n || master_reset;
    // either strobe polarity qualifies a read
    assign read_any = chip_select && (read_strobe || !read_strobe_n);
    assign req = '{write: chip_select && bus_write, read: read_any,
                   addr: bus_addr, wdata: bus_wdata};
    wire wr_ier = req.write && req.addr == uart_pin_pkg::REG_INT_ENABLE;
    wire wr_fcr = req.write && req.addr == uart_pin_pkg::REG_FIFO_CTRL;
    wire wr_flow = req.write && req.addr == uart_pin_pkg::REG_FLOW_CTRL;
    wire wr_mcr = req.write && req.addr == uart_pin_pkg::REG_MODEM_CTRL;
    wire wr_data = req.write && req.addr == uart_pin_pkg::REG_DATA;
    wire rd_data = req.read && req.addr == uart_pin_pkg::REG_DATA;
    wire rd_msr = req.read && req.addr == uart_pin_pkg::REG_MODEM_STATUS;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    wire new_enable = req.wdata[uart_pin_pkg::FCR_ENABLE_BIT];
    wire enable_change = wr_fcr && new_enable != ctrl.fifo_enable_bit;

    // next control values from register writes
    always_comb begin
        next_ctrl = ctrl;
        if (wr_ier) begin
            next_ctrl.modem_irq_enable =
                req.wdata[uart_pin_pkg::IER_MODEM_BIT];
        end
        if (wr_fcr) begin
            next_ctrl.fifo_enable_bit = new_enable;
            next_ctrl.dma_mode_select_bit =
                req.wdata[uart_pin_pkg::FCR_DMA_MODE_BIT];
            next_ctrl.trigger =
                req.wdata[uart_pin_pkg::FCR_TRIG_LSB +: 2];
        end
        if (wr_flow) begin
            next_ctrl.auto_rts = req.wdata[uart_pin_pkg::FLOW_AUTO_RTS_BIT];
        end
        if (wr_mcr) begin
            next_ctrl.rts = req.wdata[uart_pin_pkg::MCR_RTS_BIT];
            next_ctrl.loopback = req.wdata[uart_pin_pkg::MCR_LOOP_BIT];
        end
    end

    // control register file
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= uart_pin_pkg::CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ----------------------------------------------------------------
    // receive and transmit fifos
    // ----------------------------------------------------------------
    logic [CW-1:0] rx_count;
    logic [CW-1:0] tx_count;
    logic rx_fifo_ready;
    logic rx_out_valid;
    logic [DATA_WIDTH-1:0] rx_out_data;
    logic tx_fifo_ready;
    logic dma_mode;
    logic [CW-1:0] rx_trigger;

    wire rx_clear = rst || enable_change ||
        (wr_fcr && req.wdata[uart_pin_pkg::FCR_RX_CLEAR_BIT]);
    wire tx_clear = rst || enable_change ||
        (wr_fcr && req.wdata[uart_pin_pkg::FCR_TX_CLEAR_BIT]);
    wire rx_empty = rx_count == '0;
    wire tx_empty = tx_count == '0;
    // without fifos only one holding place is used
    wire rx_room = rx_fifo_ready && (ctrl.fifo_enable_bit || rx_empty);
    wire tx_room = tx_fifo_ready && (ctrl.fifo_enable_bit || tx_empty);
    wire tx_full = !tx_room;

    assign rx_ready = rx_room;
    // mode 1 only with fifos on, otherwise mode 0
    assign dma_mode = ctrl.fifo_enable_bit && ctrl.dma_mode_select_bit;
    assign rx_trigger =
        (ctrl.trigger == 2'h3) ? CW'(uart_pin_pkg::TRIG_LEVEL_3) :
        (ctrl.trigger == 2'h2) ? CW'(uart_pin_pkg::TRIG_LEVEL_2) :
        (ctrl.trigger == 2'h1) ? CW'(uart_pin_pkg::TRIG_LEVEL_1) :
        CW'(uart_pin_pkg::TRIG_LEVEL_0);

    // receive path, popped by a data read
    stream_fifo #(.WIDTH(DATA_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk(clk),
        .clear(rx_clear),
        .in_valid(rx_valid && rx_room),
        .in_ready(rx_fifo_ready),
        .in_data(rx_data),
        .out_valid(rx_out_valid),
        .out_ready(rd_data),
        .out_data(rx_out_data),
        .count(rx_count)
    );

    // transmit path, filled by a data write
    stream_fifo #(.WIDTH(DATA_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk(clk),
        .clear(tx_clear),
        .in_valid(wr_data && tx_room),
        .in_ready(tx_fifo_ready),
        .in_data(req.wdata[DATA_WIDTH-1:0]),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data),
        .count(tx_count)
    );

    // ----------------------------------------------------------------
    // ring indicator
    // ----------------------------------------------------------------
    logic ring_active;
    logic ring_change_flag;
    logic ring_rise;

    // level and sticky change, cleared by a status read
    ring_watch u_ring (
        .clk(clk),
        .clear(rst),
        .ring_n(ring_n),
        .flag_read(rd_msr),
        .ring_active(ring_active),
        .ring_change_flag(ring_change_flag),
        .ring_rise(ring_rise)
    );

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [7:0] read_value;
    wire [7:0] msr_value = (8'(ring_active) << uart_pin_pkg::MSR_RING_BIT)
        | (8'(ring_change_flag) << uart_pin_pkg::MSR_RING_CHANGE_BIT);
    wire [7:0] lsr_value = (8'(!rx_empty) << uart_pin_pkg::LSR_RX_READY_BIT)
        | (8'(tx_empty) << uart_pin_pkg::LSR_TX_EMPTY_BIT)
        | (8'(tx_empty && !tx_valid) << uart_pin_pkg::LSR_TX_IDLE_BIT);
    wire [7:0] ier_value =
        8'(ctrl.modem_irq_enable) << uart_pin_pkg::IER_MODEM_BIT;
    wire [7:0] mcr_value =
        (8'(ctrl.rts) << uart_pin_pkg::MCR_RTS_BIT)
        | (8'(ctrl.loopback) << uart_pin_pkg::MCR_LOOP_BIT);
    wire [7:0] flow_value =
        8'(ctrl.auto_rts) << uart_pin_pkg::FLOW_AUTO_RTS_BIT;
    // register select, unmapped reads give zero
    assign read_value =
        (req.addr == uart_pin_pkg::REG_DATA) ? 8'(rx_out_data) :
        (req.addr == uart_pin_pkg::REG_INT_ENABLE) ? ier_value :
        (req.addr == uart_pin_pkg::REG_INT_STATUS) ? {7'h00, !irq} :
        (req.addr == uart_pin_pkg::REG_FLOW_CTRL) ? flow_value :
        (req.addr == uart_pin_pkg::REG_MODEM_CTRL) ? mcr_value :
        (req.addr == uart_pin_pkg::REG_LINE_STATUS) ? lsr_value :
        (req.addr == uart_pin_pkg::REG_MODEM_STATUS) ? msr_value :
        uart_pin_pkg::RDATA_IDLE;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_rdata <= uart_pin_pkg::RDATA_IDLE;
        end else if (req.read) begin
            bus_rdata <= read_value;
        end else begin
            bus_rdata <= uart_pin_pkg::RDATA_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // dma ready state machines
    // ----------------------------------------------------------------
    uart_pin_pkg::dma_state_t rx_state;
    uart_pin_pkg::dma_state_t next_rx_state;
    uart_pin_pkg::dma_state_t tx_state;
    uart_pin_pkg::dma_state_t next_tx_state;
    wire rx_trig_hit = (rx_count >= rx_trigger) || rx_timeout;
    // receive burst: start at trigger or timeout, end when empty
    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            uart_pin_pkg::DMA_IDLE: begin
                if (rx_trig_hit && !rx_empty)
                    next_rx_state = uart_pin_pkg::DMA_ACTIVE;
            end
            uart_pin_pkg::DMA_ACTIVE: begin
                if (rx_empty)
                    next_rx_state = uart_pin_pkg::DMA_IDLE;
            end
            default: next_rx_state = uart_pin_pkg::DMA_IDLE;
        endcase
    end

    // transmit burst: start when empty, end when full
    always_comb begin
        next_tx_state = tx_state;
        case (tx_state)
            uart_pin_pkg::DMA_IDLE: begin
                if (tx_empty)
                    next_tx_state = uart_pin_pkg::DMA_ACTIVE;
            end
            uart_pin_pkg::DMA_ACTIVE: begin
                if (tx_full)
                    next_tx_state = uart_pin_pkg::DMA_IDLE;
            end
            default: next_tx_state = uart_pin_pkg::DMA_IDLE;
        endcase
    end

    wire rx_dma_active = dma_mode ?
        next_rx_state == uart_pin_pkg::DMA_ACTIVE : !rx_empty;
    wire tx_dma_active = dma_mode ?
        next_tx_state == uart_pin_pkg::DMA_ACTIVE : tx_empty;
    // ready outputs are active low
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_state <= uart_pin_pkg::DMA_IDLE;
            tx_state <= uart_pin_pkg::DMA_IDLE;
            rx_dma_ready_n <= 1'b1;
            tx_dma_ready_n <= 1'b1;
        end else begin
            rx_state <= next_rx_state;
            tx_state <= next_tx_state;
            rx_dma_ready_n <= !rx_dma_active;
            tx_dma_ready_n <= !tx_dma_active;
        end
    end

    // ----------------------------------------------------------------
    // modem pins and interrupt
    // ----------------------------------------------------------------
    wire rx_over_threshold = ctrl.auto_rts && rx_count >= rx_trigger;
    wire rts_off = !ctrl.rts || ctrl.loopback || rx_over_threshold;
    // rts, serial line and modem interrupt
    always_ff @(posedge clk) begin
        if (rst) begin
            rts_n <= 1'b1;
            tx_line <= 1'b1;
            irq <= 1'b0;
        end else begin
            rts_n <= rts_off;
            tx_line <= ctrl.loopback ? 1'b1 : tx_serial;
            irq <= ctrl.modem_irq_enable && ring_change_flag;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_ring_seen;
        ring_rise && ctrl.modem_irq_enable && !master_reset
        ##1 ctrl.modem_irq_enable && !master_reset;
    endsequence
    sequence s_rx_burst_start;
        dma_mode && rx_trig_hit && !rx_empty && !master_reset;
    endsequence
    AST_READ_EITHER: assert property (
        read_any && bus_addr == uart_pin_pkg::REG_INT_ENABLE && !master_reset
        |=> bus_rdata[uart_pin_pkg::IER_MODEM_BIT] ==
            $past(ctrl.modem_irq_enable))
        else $error("either read strobe must return data");
    AST_MASTER_RESET: assert property (
        master_reset |=> rts_n && !irq && rx_dma_ready_n && tx_dma_ready_n)
        else $error("master reset output levels wrong");
    AST_TX_MARK: assert property (
        master_reset |=> tx_line)
        else $error("serial output not marking after reset");
    AST_RING_LEVEL: assert property (
        rd_msr && !master_reset
        |=> bus_rdata[uart_pin_pkg::MSR_RING_BIT] == $past(ring_active))
        else $error("ring level not reported");
    AST_RING_FLAG: assert property (
        ring_rise && !master_reset |=> ring_change_flag ##1
        (ring_change_flag || $past(rd_msr) || $past(master_reset)))
        else $error("ring change flag lost");
    AST_RING_IRQ: assert property (
        s_ring_seen |=> irq)
        else $error("ring change did not raise irq");
    AST_RTS_OFF: assert property (
        (!ctrl.rts || ctrl.loopback) |=> rts_n)
        else $error("rts active while disabled");
    AST_AUTO_RTS: assert property (
        ctrl.auto_rts && rx_count >= rx_trigger |=> rts_n)
        else $error("auto rts did not drop");
    AST_NON_FIFO_MODE: assert property (
        !ctrl.fifo_enable_bit && !master_reset
        |=> rx_dma_ready_n == $past(rx_empty))
        else $error("rx ready not single transfer without fifos");
    AST_RX_MODE0: assert property (
        !dma_mode && !master_reset |=> rx_dma_ready_n == $past(rx_empty))
        else $error("rx ready wrong in mode 0");
    AST_RX_MODE1: assert property (
        s_rx_burst_start |=> !rx_dma_ready_n)
        else $error("rx ready not low at trigger");
    AST_RX_EMPTY: assert property (
        rx_empty && !rx_valid |=> rx_dma_ready_n)
        else $error("rx ready low with nothing held");
    AST_TX_MODE1: assert property (
        dma_mode && tx_full && !tx_empty && !master_reset
        |=> tx_dma_ready_n)
        else $error("tx ready low with fifo full");
    AST_TX_MODE0: assert property (
        !dma_mode && !master_reset |=> tx_dma_ready_n == !$past(tx_empty))
        else $error("tx ready wrong in mode 0");
endmodule

// ==== sim/serial_far_end.sv ====
`timescale 1ns/1ns
module serial_far_end (
    input wire logic clk,
    input wire logic send,
    input wire logic [7:0] send_data,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic drain,
    output logic tx_ready
);
    // ----------------------------------------------------------------
    // deserializer and serializer stand-in
    // ----------------------------------------------------------------
    initial rx_valid = '0;
    initial rx_data = '0;
    // offer one word, hold it until taken, then scramble the bus
    always @(posedge clk) begin
        if (send) begin
            rx_valid <= '1;
            rx_data <= send_data;
        end else if (rx_valid && rx_ready) begin
            rx_valid <= '0;
            rx_data <= ~rx_data;
        end
    end
    // serializer stalls while drain is low
    assign tx_ready = drain;
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    logic clk = '0, reset_n = '0, master_reset = '0, chip_select = '0;
    logic read_strobe = '0, read_strobe_n = '1, bus_write = '0;
    logic ring_n = '1, tx_serial = '0, rx_timeout = '0, send = '0;
    logic drain = '0, rd_pend = '0;
    logic [2:0] bus_addr = '0;
    logic [7:0] bus_wdata = '0, send_data = '0, bus_rdata, rx_data, tx_data;
    logic rts_n, tx_line, irq, rx_dma_ready_n, tx_dma_ready_n;
    logic rx_valid, rx_ready, tx_valid, tx_ready;
    logic [7:0] expq[$], txq[$], d[4];
    logic [31:0] seed = 32'h7e3c;
    int num_errors = 0, checks = 0, cycles = 0;

    always #50 clk = ~clk;
    uart_pin_control i_dut (.*);
    serial_far_end i_far (.*);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string w, input logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        chip_select <= '1;
        bus_write <= '1;
        bus_addr <= a;
        bus_wdata <= v;
        tick(1);
        bus_write <= '0;
    endtask
    // only one strobe active per read, the other stays idle
    task automatic rd(input logic [2:0] a, logic [7:0] e, logic hi);
        chip_select <= '1;
        if (hi) read_strobe <= '1;
        else read_strobe_n <= '0;
        bus_addr <= a;
        expq.push_back(e);
        tick(1);
        read_strobe <= '0;
        read_strobe_n <= '1;
    endtask
    task automatic push(input logic [7:0] v);
        send <= '1;
        send_data <= v;
        tick(1);
        send <= '0;
        tick(3);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // result watcher and hang guard
    always @(posedge clk) begin
        if (rd_pend) chk("bus_rdata", expq.pop_front(), bus_rdata);
        if (tx_valid && tx_ready)
            chk("tx_data", txq.pop_front(), tx_data);
        rd_pend <= chip_select && (read_strobe || !read_strobe_n);
        cycles++;
        if (cycles > 6000) begin
            num_errors++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        tick(5);
        reset_n <= '1;
        tick(2);
        wr(uart_pin_pkg::REG_MODEM_CTRL, 8'h02);
        tick(3);
        chk("rts_n", 8'h00, rts_n);
        wr(uart_pin_pkg::REG_MODEM_CTRL, 8'h12);
        tick(3);
        chk("rts_n", 8'h01, rts_n);
        wr(uart_pin_pkg::REG_MODEM_CTRL, 8'h02);
        $display("rts test ended");
        tick(1);
        wr(uart_pin_pkg::REG_INT_ENABLE, 8'h08);
        rd(uart_pin_pkg::REG_INT_ENABLE, 8'h08, '0);
        ring_n <= '0;
        tick(3);
        rd(uart_pin_pkg::REG_MODEM_STATUS, 8'h40, '1);
        ring_n <= '1;
        tick(4);
        chk("irq", 8'h01, irq);
        rd(uart_pin_pkg::REG_MODEM_STATUS, 8'h04, '0);
        tick(3);
        chk("irq", 8'h00, irq);
        rd(uart_pin_pkg::REG_MODEM_STATUS, 8'h00, '1);
        $display("ring test ended");
        seed = lfsr(seed);
        push(seed[7:0]);
        chk("rx_dma_ready_n", 8'h00, rx_dma_ready_n);
        rd(uart_pin_pkg::REG_DATA, seed[7:0], '0);
        tick(3);
        chk("rx_dma_ready_n", 8'h01, rx_dma_ready_n);
        chk("tx_dma_ready_n", 8'h00, tx_dma_ready_n);
        txq.push_back(seed[15:8]);
        wr(uart_pin_pkg::REG_DATA, seed[15:8]);
        tick(3);
        chk("tx_dma_ready_n", 8'h01, tx_dma_ready_n);
        drain <= '1;
        tick(5);
        chk("tx_dma_ready_n", 8'h00, tx_dma_ready_n);
        drain <= '0;
        $display("mode 0 test ended");
        wr(uart_pin_pkg::REG_FIFO_CTRL, 8'h49);
        tick(1);
        wr(uart_pin_pkg::REG_FLOW_CTRL, 8'h40);
        for (int i = 0; i < 4; i++) begin
            tick(2);
            chk("rx_dma_ready_n", 8'h01, rx_dma_ready_n);
            chk("rts_n", 8'h00, rts_n);
            seed = lfsr(seed);
            d[i] = seed[7:0];
            push(d[i]);
        end
        chk("rts_n", 8'h01, rts_n);
        for (int i = 0; i < 4; i++) begin
            chk("rx_dma_ready_n", 8'h00, rx_dma_ready_n);
            rd(uart_pin_pkg::REG_DATA, d[i], i[0]);
            tick(2);
        end
        chk("rx_dma_ready_n", 8'h01, rx_dma_ready_n);
        chk("rts_n", 8'h00, rts_n);
        seed = lfsr(seed);
        push(seed[7:0]);
        chk("rx_dma_ready_n", 8'h01, rx_dma_ready_n);
        rx_timeout <= '1;
        tick(2);
        chk("rx_dma_ready_n", 8'h00, rx_dma_ready_n);
        rx_timeout <= '0;
        rd(uart_pin_pkg::REG_DATA, seed[7:0], '1);
        tick(2);
        chk("rx_dma_ready_n", 8'h01, rx_dma_ready_n);
        for (int i = 0; i < 16; i++) begin
            tick(2);
            chk("tx_dma_ready_n", 8'h00, tx_dma_ready_n);
            seed = lfsr(seed);
            txq.push_back(seed[7:0]);
            wr(uart_pin_pkg::REG_DATA, seed[7:0]);
        end
        tick(3);
        chk("tx_dma_ready_n", 8'h01, tx_dma_ready_n);
        drain <= '1;
        tick(40);
        chk("tx_dma_ready_n", 8'h00, tx_dma_ready_n);
        chk("tx_left", 8'h00, 8'(txq.size()));
        $display("mode 1 test ended");
        master_reset <= '1;
        tick(1);
        master_reset <= '0;
        tick(1);
        chk("tx_line", 8'h01, tx_line);
        chk("tx_dma_ready_n", 8'h01, tx_dma_ready_n);
        chk("irq", 8'h00, irq);
        $display("master reset test ended");
        end_sim();
    end
endmodule
